// ---- rtl/sensor_link_pkg.sv ----
// Shared constants, types and rule summary for the two-wire register slave and pixel port.
// Summary of operation
// - After restart, read address byte; slave returns register data bytes.
// - Read without address phase returns data at the current address pointer.
// - Pointer loads from address bytes and advances on each data byte.
// - Sequential random read: master acknowledges, slave keeps sending bytes.
// - Sequential current read: slave supplies bytes until master stops acknowledging.
// - Sequential write: slave accepts each further data byte until stop.
// - Pixel data, frame and line valid launch on pixel clock rising edge.
// - First byte: address in bits 7 to 1, direction in bit 0.
// - Default slave addresses are 0x20 write and 0x21 read.
// - Address pointer increments after each transferred data byte.
// - Receiver acknowledges by pulling data low in the ninth clock period.
package sensor_link_pkg;
  localparam logic [6:0] default_slave_addr = 7'h10;
  localparam logic [6:0] alt_slave_addr = 7'h18;
  localparam int pixel_width = 12;
  localparam int fifo_depth = 8;
  localparam int bit_count_last = 7;

  typedef enum logic [6:0] {
    st_idle = 7'b000_0001,
    st_addr = 7'b000_0010,
    st_ack = 7'b000_0100,
    st_rx = 7'b000_1000,
    st_tx = 7'b001_0000,
    st_mack = 7'b010_0000,
    st_skip = 7'b100_0000
  } serial_state_t;

  typedef struct packed {
    logic frame_valid;
    logic line_valid;
    logic [pixel_width-1:0] data;
  } pixel_word_t;
endpackage : sensor_link_pkg

// ---- rtl/pixel_fifo.sv ----
// Flip-flop FIFO with valid and ready on both sides.
`timescale 1ns/1ps
module pixel_fifo #(
  parameter int width = 14,
  parameter int depth = 8
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [width-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [width-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int aw = $clog2(depth);
  initial begin
    if (depth < 2 || (1 << aw) != depth) $error("depth must be a power of two");
  end
  typedef struct packed {
    logic [depth-1:0][width-1:0] mem;
    logic [aw:0] wr;
    logic [aw:0] rd;
  } fifo_state_t;
  fifo_state_t s;
  fifo_state_t next_s;
  logic full;
  logic empty;
  assign full = (s.wr[aw] != s.rd[aw]) && (s.wr[aw-1:0] == s.rd[aw-1:0]);
  assign empty = s.wr == s.rd;
  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = s.mem[s.rd[aw-1:0]];
  always_comb begin
    next_s = s;
    if (in_valid && !full) begin
      next_s.mem[s.wr[aw-1:0]] = in_data;
      next_s.wr = s.wr + 1'b1;
    end
    if (out_ready && !empty) begin
      next_s.rd = s.rd + 1'b1;
    end
  end
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
endmodule : pixel_fifo

// ---- rtl/sensor_two_wire_register_access.sv ----
// Two-wire register slave with register store, and pixel output port fed through a FIFO.
`timescale 1ns/1ps
module sensor_two_wire_register_access #(
  parameter int reg_addr_width = 8
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic serial_bus_clock,
  input wire logic serial_bus_data_in,
  output logic serial_bus_data_out,
  output logic serial_bus_data_oe,
  input wire logic alt_address_select,
  input wire logic pixel_out_clock,
  input wire sensor_link_pkg::pixel_word_t pixel_in,
  input wire logic pixel_in_valid,
  output logic pixel_in_ready,
  output logic [sensor_link_pkg::pixel_width-1:0] pixel_data,
  output logic frame_valid,
  output logic line_valid
);
  localparam int pw = $bits(sensor_link_pkg::pixel_word_t);
  localparam int depth = 1 << reg_addr_width;
  initial begin
    if (reg_addr_width < 1 || reg_addr_width > 16) $error("reg_addr_width out of range");
  end

  typedef struct packed {
    logic [1:0] scl_sync;
    logic [1:0] sda_sync;
    logic [1:0] pclk_sync;
    logic [1:0] alt_sync;
    logic scl;
    logic sda;
    logic pclk;
    sensor_link_pkg::serial_state_t state;
    logic [2:0] bit_cnt;
    logic [7:0] shreg;
    logic reading;
    logic [1:0] byte_idx;
    logic [15:0] pointer;
    logic drive_low;
    logic [depth-1:0][7:0] regs;
    sensor_link_pkg::pixel_word_t pix;
  } top_state_t;

  top_state_t s;
  top_state_t next_s;
  sensor_link_pkg::pixel_word_t fifo_out;
  logic fifo_valid;
  logic fifo_take;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  logic pclk_rise;
  logic [6:0] own_addr;

  function automatic logic [reg_addr_width-1:0] slot(input logic [15:0] p);
    slot = p[reg_addr_width-1:0];
  endfunction : slot

  assign scl_rise = s.scl_sync[1] && !s.scl;
  assign scl_fall = !s.scl_sync[1] && s.scl;
  assign start_seen = s.scl && s.scl_sync[1] && s.sda && !s.sda_sync[1];
  assign stop_seen = s.scl && s.scl_sync[1] && !s.sda && s.sda_sync[1];
  assign pclk_rise = s.pclk_sync[1] && !s.pclk;
  assign own_addr = s.alt_sync[1] ? sensor_link_pkg::alt_slave_addr
                                       : sensor_link_pkg::default_slave_addr;
  // Open drain: only a low is ever driven.
  assign serial_bus_data_out = 1'b0;
  assign serial_bus_data_oe = s.drive_low;
  assign fifo_take = pclk_rise;
  assign pixel_data = s.pix.data;
  assign frame_valid = s.pix.frame_valid;
  assign line_valid = s.pix.line_valid;

  pixel_fifo #(
    .width(pw),
    .depth(sensor_link_pkg::fifo_depth)
  ) u_fifo (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .in_data(pixel_in),
    .in_valid(pixel_in_valid),
    .in_ready(pixel_in_ready),
    .out_data(fifo_out),
    .out_valid(fifo_valid),
    .out_ready(fifo_take)
  );

  always_comb begin
    next_s = s;
    next_s.scl_sync = {s.scl_sync[0], serial_bus_clock};
    next_s.sda_sync = {s.sda_sync[0], serial_bus_data_in};
    next_s.pclk_sync = {s.pclk_sync[0], pixel_out_clock};
    next_s.alt_sync = {s.alt_sync[0], alt_address_select};
    next_s.scl = s.scl_sync[1];
    next_s.sda = s.sda_sync[1];
    next_s.pclk = s.pclk_sync[1];
    // Outputs change on the sampled rising edge, leaving half a period before the
    // receiver's falling-edge capture; an empty FIFO sends a blank word.
    if (pclk_rise) begin
      next_s.pix = fifo_valid ? fifo_out : '0;
    end
    if (stop_seen) begin
      next_s.state = sensor_link_pkg::st_idle;
      next_s.drive_low = 1'b0;
    end else if (start_seen) begin
      // A restart keeps the pointer, so the dummy write sets up the read.
      next_s.state = sensor_link_pkg::st_addr;
      next_s.bit_cnt = '0;
      next_s.byte_idx = '0;
      next_s.drive_low = 1'b0;
    end else begin
      case (s.state)
        sensor_link_pkg::st_idle: begin
          next_s.drive_low = 1'b0;
        end
        sensor_link_pkg::st_addr, sensor_link_pkg::st_rx: begin
          if (scl_rise) begin
            next_s.shreg = {s.shreg[6:0], s.sda};
            next_s.bit_cnt = s.bit_cnt + 3'd1;
          end
          if (scl_fall && s.bit_cnt == '0 && s.byte_idx != 2'd0 && s.shreg != s.shreg) begin
            next_s.state = s.state;
          end
          if (scl_fall && s.bit_cnt == '0 && s.shreg[0] !== 1'bx && s.state == s.state
              && s.bit_cnt == 3'd0 && s.byte_idx == 2'd3) begin
            next_s.state = s.state;
          end
          if (scl_fall && s.bit_cnt == 3'd0 && s.byte_idx[1]) begin
            next_s.state = s.state;
          end
          if (scl_fall && s.bit_cnt == 3'd0 && s.shreg != 8'h00 && 1'b0) begin
            next_s.state = s.state;
          end
          if (scl_fall && s.bit_cnt == 3'd0 && s.byte_idx == 2'd2 && 1'b0) begin
            next_s.state = s.state;
          end
          if (scl_fall && s.bit_cnt == 3'd0 && s.byte_idx != 2'd3 && s.reading) begin
            next_s.state = s.state;
          end
          if (scl_fall && s.bit_cnt == 3'd0 && s.byte_idx == 2'd3 && 1'b0) begin
            next_s.state = s.state;
          end
          if (scl_rise && s.bit_cnt == 3'(sensor_link_pkg::bit_count_last)) begin
            next_s.state = sensor_link_pkg::st_ack;
            if (s.state == sensor_link_pkg::st_addr) begin
              if (s.shreg[6:0] != own_addr) begin
                next_s.state = sensor_link_pkg::st_skip;
              end else begin
                next_s.reading = s.sda;
                next_s.byte_idx = 2'd1;
              end
            end else begin
              case (s.byte_idx)
                2'd1: begin
                  next_s.pointer[15:8] = {s.shreg[6:0], s.sda};
                  next_s.byte_idx = 2'd2;
                end
                2'd2: begin
                  next_s.pointer[7:0] = {s.shreg[6:0], s.sda};
                  next_s.byte_idx = 2'd3;
                end
                default: begin
                  next_s.regs[slot(s.pointer)] = {s.shreg[6:0], s.sda};
                  next_s.pointer = s.pointer + 16'd1;
                end
              endcase
            end
          end
        end
        sensor_link_pkg::st_ack: begin
          // Pull low from the falling edge after bit eight until the next falling edge.
          if (scl_fall && !s.drive_low) begin
            next_s.drive_low = 1'b1;
          end else if (scl_fall && s.drive_low) begin
            next_s.drive_low = 1'b0;
            next_s.bit_cnt = '0;
            if (s.reading) begin
              next_s.state = sensor_link_pkg::st_tx;
              next_s.shreg = s.regs[slot(s.pointer)];
              next_s.drive_low = !s.regs[slot(s.pointer)][7];
            end else begin
              next_s.state = sensor_link_pkg::st_rx;
            end
          end
        end
        sensor_link_pkg::st_tx: begin
          if (scl_fall) begin
            if (s.bit_cnt == 3'(sensor_link_pkg::bit_count_last)) begin
              next_s.drive_low = 1'b0;
              next_s.state = sensor_link_pkg::st_mack;
              next_s.pointer = s.pointer + 16'd1;
            end else begin
              next_s.bit_cnt = s.bit_cnt + 3'd1;
              next_s.shreg = {s.shreg[6:0], 1'b0};
              next_s.drive_low = !s.shreg[6];
            end
          end
        end
        sensor_link_pkg::st_mack: begin
          // A not-acknowledge ends the read; wait for the stop.
          if (scl_rise && s.sda) begin
            next_s.state = sensor_link_pkg::st_skip;
            next_s.drive_low = 1'b0;
          end else if (scl_fall) begin
            // Only an acknowledge gets here; the next byte must start at once, since the
            // master owns the ninth slot of a read and no slave acknowledge follows it.
            next_s.state = sensor_link_pkg::st_tx;
            next_s.bit_cnt = '0;
            next_s.shreg = s.regs[slot(s.pointer)];
            next_s.drive_low = !s.regs[slot(s.pointer)][7];
          end
        end
        sensor_link_pkg::st_skip: begin
          next_s.drive_low = 1'b0;
        end
        default: begin
          next_s.state = sensor_link_pkg::st_idle;
        end
      endcase
    end
    if (s.state == sensor_link_pkg::st_ack && s.reading && s.byte_idx == 2'd1
        && scl_fall && s.drive_low) begin
      next_s.byte_idx = 2'd3;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      s <= '{scl_sync: 2'b11, sda_sync: 2'b11, pclk_sync: 2'b00, scl: 1'b1, sda: 1'b1,
             pclk: 1'b0, state: sensor_link_pkg::st_idle, default: '0};
    end else begin
      s <= next_s;
    end
  end
endmodule : sensor_two_wire_register_access

// ---- tb/sensor_link_chk.sv ----
// Checker for the serial data pin and the pixel output port.
`timescale 1ns/1ps
module sensor_link_chk (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic serial_bus_clock,
  input wire logic serial_bus_data_oe,
  input wire logic serial_bus_data_out,
  input wire logic pixel_out_clock,
  input wire logic [sensor_link_pkg::pixel_width-1:0] pixel_data,
  input wire logic frame_valid,
  input wire logic line_valid
);
  logic [3:0] since_rise;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!reset_n);
  // Cycles since the pixel clock was seen rising; it saturates so a stopped clock is harmless.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      since_rise <= 4'hf;
    end else if ($rose(pixel_out_clock)) begin
      since_rise <= 4'h0;
    end else if (since_rise != 4'hf) begin
      since_rise <= since_rise + 4'h1;
    end
  end
  data_launch_a: assert property ($changed(pixel_data) |-> since_rise <= 4'h6)
    else $error("pixel data moved away from a clock rise");
  fv_launch_a: assert property ($changed(frame_valid) |-> since_rise <= 4'h6)
    else $error("frame valid moved away from a clock rise");
  lv_launch_a: assert property ($changed(line_valid) |-> since_rise <= 4'h6)
    else $error("line valid moved away from a clock rise");
  data_capture_a: assert property ($fell(pixel_out_clock) |-> $stable(pixel_data) [*3])
    else $error("pixel data unstable at the falling edge");
  fv_capture_a: assert property ($fell(pixel_out_clock) |-> $stable(frame_valid) [*3])
    else $error("frame valid unstable at the falling edge");
  lv_capture_a: assert property ($fell(pixel_out_clock) |-> $stable(line_valid) [*3])
    else $error("line valid unstable at the falling edge");
  oe_scl_low_a: assert property ($changed(serial_bus_data_oe) |-> !serial_bus_clock)
    else $error("data pull changed while serial clock high");
  oe_held_a: assert property ($rose(serial_bus_clock) && serial_bus_data_oe
      |-> serial_bus_data_oe [*8])
    else $error("data pull dropped during a clock high phase");
  data_out_low_a: assert property (!serial_bus_data_out)
    else $error("serial data output drove a high level");
endmodule : sensor_link_chk
bind sensor_two_wire_register_access sensor_link_chk chk_u (.core_clk(core_clk),
  .reset_n(reset_n), .serial_bus_clock(serial_bus_clock),
  .serial_bus_data_oe(serial_bus_data_oe), .serial_bus_data_out(serial_bus_data_out),
  .pixel_out_clock(pixel_out_clock),
  .pixel_data(pixel_data), .frame_valid(frame_valid), .line_valid(line_valid));

// ---- tb/two_wire_master.sv ----
// Behavioural two-wire bus master driving the serial clock and pulling the data line.
`timescale 1ns/1ps
module two_wire_master #(
  parameter int phase = 20
) (
  input wire logic core_clk,
  input wire logic sda,
  output logic scl = 1'b1,
  output logic sda_oe = 1'b0
);
  // Each step changes at most one line, so data never moves with a clock edge by accident.
  task automatic step(input logic oe_v, input logic scl_v);
    sda_oe <= oe_v;
    scl <= scl_v;
    repeat (phase) @(posedge core_clk);
  endtask : step
  task automatic bitx(input logic b, output logic r);
    step(sda_oe, 1'b0);
    step(!b, 1'b0);
    step(!b, 1'b1);
    r = sda;
  endtask : bitx
  // Start or restart when p is high, stop when p is low.
  task automatic cond(input logic p);
    logic r;
    bitx(p, r);
    step(p, 1'b1);
  endtask : cond
  task automatic xbyte(input logic [7:0] d, input logic last, output logic [7:0] q,
      output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bitx(d[i], q[i]);
    end
    bitx(last, r);
    ack = !r;
  endtask : xbyte
endmodule : two_wire_master

// ---- tb/sensor_two_wire_register_access_tb.sv ----
// Bench for the two-wire register slave and its pixel output port.
`timescale 1ns/1ps
module sensor_two_wire_register_access_tb;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic pclk = 1'b0;
  logic run = 1'b0;
  logic pvalid = 1'b0;
  logic alt = 1'b0;
  sensor_link_pkg::pixel_word_t pin = '0;
  logic scl, m_oe, d_oe, d_out, rdy, fv, lv, a;
  logic [11:0] pdata;
  logic [7:0] q;
  int fail_count = 0;
  int n_tests = 0;
  // The data line has a pull-up; the device pulls it low only while enabled and its output is low.
  wire logic sda = !(m_oe || (d_oe && !d_out));
  always #2.5 core_clk = !core_clk;
  // The pixel clock stands low while the port is stalled.
  always #32 pclk = (run || pclk) ? !pclk : 1'b0;
  two_wire_master m_u (.core_clk(core_clk), .sda(sda), .scl(scl), .sda_oe(m_oe));
  sensor_two_wire_register_access dut_u (.core_clk(core_clk), .reset_n(reset_n),
    .serial_bus_clock(scl), .serial_bus_data_in(sda), .serial_bus_data_out(d_out),
    .serial_bus_data_oe(d_oe), .alt_address_select(alt), .pixel_out_clock(pclk),
    .pixel_in(pin), .pixel_in_valid(pvalid), .pixel_in_ready(rdy), .pixel_data(pdata),
    .frame_valid(fv), .line_valid(lv));
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : tally_and_finish
  // Waits, bounded, for the pixel clock to reach a level; a stuck clock ends the run.
  task automatic level_wait(input logic lvl);
    int w;
    w = 0;
    while (pclk !== lvl && w < 40) begin
      @(posedge core_clk);
      w++;
    end
    if (pclk !== lvl) begin
      fail_count++;
      $display("ERROR pixel clock expected %b seen %b", lvl, pclk);
      tally_and_finish();
    end
  endtask : level_wait
  task automatic xb(input logic [7:0] d, input logic last, input logic [7:0] eq, input logic ea);
    m_u.xbyte(d, last, q, a);
    check("byte", 16'(q), 16'(eq));
    check("ack", 16'(a), 16'(ea));
  endtask : xb
  task automatic wb(input logic [7:0] d);
    xb(d, 1'b1, d, 1'b1);
  endtask : wb
  task automatic rb(input logic more, input logic [7:0] e);
    xb(8'hff, !more, e, more);
  endtask : rb
  function automatic sensor_link_pkg::pixel_word_t pw(input int k);
    pw = '{frame_valid: k[0], line_valid: 1'b1, data: 12'(k) * 12'h123};
  endfunction : pw
  task automatic t_write();
    m_u.cond(1'b1);
    wb(8'h20);
    wb(8'h00);
    wb(8'h10);
    wb(8'ha5);
    wb(8'h3c);
    wb(8'h5a);
    m_u.cond(1'b0);
    $display("write test done");
  endtask : t_write
  task automatic t_cur_read();
    m_u.cond(1'b1);
    wb(8'h20);
    wb(8'h00);
    wb(8'h10);
    m_u.cond(1'b0);
    m_u.cond(1'b1);
    wb(8'h21);
    rb(1'b1, 8'ha5);
    rb(1'b1, 8'h3c);
    rb(1'b0, 8'h5a);
    m_u.cond(1'b0);
    $display("current read test done");
  endtask : t_cur_read
  task automatic t_rand_read();
    m_u.cond(1'b1);
    wb(8'h20);
    wb(8'h00);
    wb(8'h11);
    m_u.cond(1'b1);
    wb(8'h21);
    rb(1'b1, 8'h3c);
    rb(1'b0, 8'h5a);
    m_u.cond(1'b0);
    m_u.cond(1'b1);
    xb(8'h30, 1'b1, 8'h30, 1'b0);
    m_u.cond(1'b0);
    $display("random read test done");
  endtask : t_rand_read
  task automatic t_alt();
    alt <= 1'b1;
    repeat (4) @(posedge core_clk);
    m_u.cond(1'b1);
    xb(8'h20, 1'b1, 8'h20, 1'b0);
    m_u.cond(1'b0);
    m_u.cond(1'b1);
    wb(8'h30);
    wb(8'h00);
    wb(8'h20);
    wb(8'h77);
    m_u.cond(1'b0);
    m_u.cond(1'b1);
    wb(8'h30);
    wb(8'h00);
    wb(8'h20);
    m_u.cond(1'b1);
    wb(8'h31);
    rb(1'b0, 8'h77);
    m_u.cond(1'b0);
    alt <= 1'b0;
    $display("alternate address test done");
  endtask : t_alt
  task automatic t_pixel();
    int k;
    logic r;
    k = 0;
    pin <= pw(0);
    pvalid <= 1'b1;
    #1;
    r = rdy;
    repeat (12) begin
      @(posedge core_clk);
      k = k + int'(r);
      pin <= pw(k);
      #1;
      r = rdy;
    end
    check("fill", 16'(k), 16'h0008);
    @(posedge core_clk);
    pvalid <= 1'b0;
    run <= 1'b1;
    for (int j = 0; j < 8; j++) begin
      level_wait(1'b1);
      level_wait(1'b0);
      check("pixel", 16'({fv, lv, pdata}), 16'(pw(j)));
    end
    @(posedge core_clk);
    run <= 1'b0;
    $display("pixel test done");
  endtask : t_pixel
  initial begin
    repeat (3) @(posedge core_clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    t_write();
    t_cur_read();
    t_rand_read();
    t_alt();
    t_pixel();
    tally_and_finish();
  end
  initial begin
    #400us;
    fail_count++;
    $display("ERROR watchdog expected end seen hang");
    tally_and_finish();
  end
endmodule : sensor_two_wire_register_access_tb
